// File: core/card_lock_pkg.sv
// What this block does
// - lock parameter byte: bit3 erase, bit2 lock, bit1 clear password, bit0 set password
// - lock state shows in status bit 25, failed lock operation in bit 24
// - erase request with any other request bit set is rejected with error
// - revision 1.10 build must use type 2; revision 1.01 may use either
// - type 2: codes 0011b, 0111b, 0110b and undefined codes end in error
// - type 1: 0011b runs as 0001b, 0111b as 0101b, 0110b as 0010b
// - type 2: erase under permanent protection fails, lock stays, error set
// - type 1: erase wins, sets permanent protection, unlocks after erase ends
// - type 2: successful erase clears temporary and group write protection
// - type 1: erase leaves temporary and group protection for host to clear
// - clear password 0010/0110 on empty password: type 2 error, type 1 none
// - without permanent protection, erase of locked card unlocks, error stays 0
// - forced erase covers the user area only, secure area kept
// - card stays locked through the erase, unlocks once erase has finished
// - temporary and group protection held until the erase has finished
// - erase errors do not stop the forced erase
// - bus width command refused while locked, accepted in any width unlocked
// - width stays as it was while locked, reset command returns 1-bit
// - locked: only basic, lock class, block length and ACMD41 accepted
// - locked: all other commands answer as illegal command
// - lock flag appears in responses to select and status commands
package card_lock_pkg;
  localparam int STATUS_W = 32;
  localparam int BIT_LOCKED = 25;
  localparam int BIT_LOCK_ERR = 24;
  localparam int BIT_ILLEGAL = 22;
  localparam int BIT_APP_CMD = 5;
  localparam int PARAM_ERASE = 3;
  localparam int PARAM_LOCK = 2;
  localparam int PARAM_CLR = 1;
  localparam int PARAM_SET = 0;
  localparam logic [3:0] CODE_ERASE = 4'h8;
  localparam logic [3:0] CODE_LOCK = 4'h4;
  localparam logic [3:0] CODE_SET_LOCK = 4'h5;
  localparam logic [3:0] CODE_CLR = 4'h2;
  localparam logic [3:0] CODE_SET = 4'h1;
  localparam logic [3:0] CODE_UNLOCK = 4'h0;
  localparam logic [3:0] CODE_T1_SET = 4'h3;
  localparam logic [3:0] CODE_T1_SET_LOCK = 4'h7;
  localparam logic [3:0] CODE_T1_CLR = 4'h6;
  localparam logic [5:0] CMD_RESET = 6'h00;
  localparam logic [5:0] CMD_ALL_CID = 6'h02;
  localparam logic [5:0] CMD_REL_ADDR = 6'h03;
  localparam logic [5:0] CMD_SET_DSR = 6'h04;
  localparam logic [5:0] CMD_SELECT = 6'h07;
  localparam logic [5:0] CMD_SEND_CSD = 6'h09;
  localparam logic [5:0] CMD_SEND_CID = 6'h0a;
  localparam logic [5:0] CMD_STOP = 6'h0c;
  localparam logic [5:0] CMD_STATUS = 6'h0d;
  localparam logic [5:0] CMD_INACTIVE = 6'h0f;
  localparam logic [5:0] CMD_BLOCK_LEN = 6'h10;
  localparam logic [5:0] CMD_LOCK = 6'h2a;
  localparam logic [5:0] CMD_APP = 6'h37;
  localparam logic [5:0] ACMD_BUS_WIDTH = 6'h06;
  localparam logic [5:0] ACMD_OP_COND = 6'h29;
  localparam logic RST_LOCK = 1'b0;
  localparam logic RST_WIDTH4 = 1'b0;
  localparam int SYNC_W = 16;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ERASE = 2'b10
  } erase_state_e;
endpackage

// File: core/pin_sync.sv
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  if (WIDTH < 1) begin : bad_width
    $error("pin_sync width must be at least one");
  end

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // pin_sync

// File: core/card_lock_unlock_control.sv
module card_lock_unlock_control #(
  parameter bit LOCK_TYPE2 = 1'b1,
  parameter bit SPEC_V110 = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sd_clk_in,
  input wire logic cmd_strobe_in,
  input wire logic [5:0] cmd_index_in,
  input wire logic bus_width4_arg_in,
  input wire logic param_strobe_in,
  input wire logic [7:0] lock_param_in,
  input wire logic password_exists_in,
  input wire logic password_match_in,
  input wire logic permanent_write_protect_in,
  input wire logic temporary_write_protect_in,
  input wire logic group_write_protect_in,
  input wire logic erase_done_in,
  input wire logic erase_error_in,
  output logic resp_valid_out,
  output logic [card_lock_pkg::STATUS_W-1:0] resp_status_out,
  output logic lock_state_flag_out,
  output logic lock_op_error_flag_out,
  output logic bus_width4_out,
  output logic erase_user_area_out,
  output logic erase_busy_out,
  output logic password_clear_out,
  output logic password_write_out,
  output logic permanent_write_protect_set_out,
  output logic temporary_write_protect_clear_out,
  output logic group_write_protect_clear_out
);
  // fixed at build time only
  if (SPEC_V110 && !LOCK_TYPE2) begin : bad_type
    $error("a revision 1.10 card must use type 2 lock behaviour");
  end

  // remap of legacy parameter codes
  function automatic logic [3:0] lock_code(input logic [3:0] raw, input logic type2);
    logic [3:0] code;
    code = raw;
    if (!type2) begin
      case (raw)
        card_lock_pkg::CODE_T1_SET: code = card_lock_pkg::CODE_SET;
        card_lock_pkg::CODE_T1_SET_LOCK: code = card_lock_pkg::CODE_SET_LOCK;
        card_lock_pkg::CODE_T1_CLR: code = card_lock_pkg::CODE_CLR;
        default: code = raw;
      endcase
    end
    return code;
  endfunction

  // commands a locked card still serves
  function automatic logic locked_ok(input logic [5:0] idx, input logic app);
    logic ok;
    ok = 1'b0;
    if (app) begin
      ok = (idx == card_lock_pkg::ACMD_OP_COND);
    end else begin
      case (idx)
        card_lock_pkg::CMD_RESET,
        card_lock_pkg::CMD_ALL_CID,
        card_lock_pkg::CMD_REL_ADDR,
        card_lock_pkg::CMD_SET_DSR,
        card_lock_pkg::CMD_SELECT,
        card_lock_pkg::CMD_SEND_CSD,
        card_lock_pkg::CMD_SEND_CID,
        card_lock_pkg::CMD_STOP,
        card_lock_pkg::CMD_STATUS,
        card_lock_pkg::CMD_INACTIVE,
        card_lock_pkg::CMD_BLOCK_LEN,
        card_lock_pkg::CMD_LOCK,
        card_lock_pkg::CMD_APP: ok = 1'b1;
        default: ok = 1'b0;
      endcase
    end
    return ok;
  endfunction

  // link pins through two flops
  logic [card_lock_pkg::SYNC_W-1:0] pins_raw;
  logic [card_lock_pkg::SYNC_W-1:0] pins_s;
  assign pins_raw = {sd_clk_in, cmd_strobe_in, cmd_index_in, bus_width4_arg_in,
                     param_strobe_in, lock_param_in[3:0], 2'h0};

  pin_sync #(
    .WIDTH(card_lock_pkg::SYNC_W)
  ) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  logic sd_clk_s;
  logic cmd_strobe_s;
  logic [5:0] cmd_index_s;
  logic width4_arg_s;
  logic param_strobe_s;
  logic [3:0] param_s;
  assign sd_clk_s = pins_s[15];
  assign cmd_strobe_s = pins_s[14];
  assign cmd_index_s = pins_s[13:8];
  assign width4_arg_s = pins_s[7];
  assign param_strobe_s = pins_s[6];
  assign param_s = pins_s[5:2];

  logic sd_clk_prev_q;
  logic sd_rise;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sd_clk_prev_q <= 1'b0;
    end else begin
      sd_clk_prev_q <= sd_clk_s;
    end
  end
  assign sd_rise = sd_clk_s && !sd_clk_prev_q;

  logic cmd_ev;
  logic param_ev;
  assign cmd_ev = sd_rise && cmd_strobe_s;
  assign param_ev = sd_rise && param_strobe_s && !cmd_strobe_s;

  // application prefix tracking
  logic app_q;
  logic is_app;
  assign is_app = app_q;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      app_q <= 1'b0;
    end else if (cmd_ev) begin
      app_q <= !app_q && (cmd_index_s == card_lock_pkg::CMD_APP);
    end
  end

  logic init_q;
  logic lock_q;
  logic err_q;
  logic width4_q;
  card_lock_pkg::erase_state_e state_q;
  logic erase_type1_pwp_q;

  logic accept;
  assign accept = cmd_ev && (!lock_q || locked_ok(cmd_index_s, is_app));

  // lock parameter evaluation
  logic [3:0] code;
  logic busy;
  logic r_err;
  logic r_lock;
  logic r_unlock;
  logic r_erase;
  logic r_clr;
  logic r_set;
  logic pw_ok;
  assign code = lock_code(param_s, LOCK_TYPE2);
  assign busy = (state_q == card_lock_pkg::ST_ERASE);
  assign pw_ok = !password_exists_in || password_match_in;

  always_comb begin
    r_err = 1'b0;
    r_lock = 1'b0;
    r_unlock = 1'b0;
    r_erase = 1'b0;
    r_clr = 1'b0;
    r_set = 1'b0;
    case (code)
      card_lock_pkg::CODE_ERASE: begin
        if (!lock_q || !password_exists_in) begin
          r_err = 1'b1;
        end else if (permanent_write_protect_in && LOCK_TYPE2) begin
          r_err = 1'b1;
        end else begin
          r_erase = 1'b1;
        end
      end
      card_lock_pkg::CODE_LOCK: begin
        r_err = lock_q || !password_exists_in || !password_match_in;
        r_lock = !r_err;
      end
      card_lock_pkg::CODE_SET_LOCK: begin
        r_err = !pw_ok;
        r_set = pw_ok;
        r_lock = pw_ok;
      end
      card_lock_pkg::CODE_CLR: begin
        if (!password_exists_in) begin
          r_err = LOCK_TYPE2;
        end else begin
          r_err = !password_match_in;
          r_clr = password_match_in;
          r_unlock = password_match_in;
        end
      end
      card_lock_pkg::CODE_SET: begin
        r_err = !pw_ok;
        r_set = pw_ok;
        r_unlock = pw_ok;
      end
      card_lock_pkg::CODE_UNLOCK: begin
        r_err = !lock_q || !password_exists_in || !password_match_in;
        r_unlock = !r_err;
      end
      default: begin
        r_err = 1'b1;
      end
    endcase
    if (busy) begin
      r_err = 1'b1;
      r_lock = 1'b0;
      r_unlock = 1'b0;
      r_erase = 1'b0;
      r_clr = 1'b0;
      r_set = 1'b0;
    end
  end

  // forced erase sequencer
  logic erase_start;
  logic erase_end;
  assign erase_start = param_ev && r_erase;
  // erase faults are not fatal; the engine destroys failing sectors
  assign erase_end = busy && erase_done_in;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= card_lock_pkg::ST_IDLE;
      erase_type1_pwp_q <= 1'b0;
    end else begin
      case (state_q)
        card_lock_pkg::ST_IDLE: begin
          if (erase_start) begin
            state_q <= card_lock_pkg::ST_ERASE;
            erase_type1_pwp_q <= permanent_write_protect_in;
          end
        end
        card_lock_pkg::ST_ERASE: begin
          if (erase_end) begin
            state_q <= card_lock_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= card_lock_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // lock state, caught from the password store after reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      init_q <= 1'b1;
      lock_q <= card_lock_pkg::RST_LOCK;
    end else if (init_q) begin
      init_q <= 1'b0;
      lock_q <= password_exists_in;
    end else if (erase_end) begin
      lock_q <= 1'b0;
    end else if (param_ev && r_lock) begin
      lock_q <= 1'b1;
    end else if (param_ev && r_unlock) begin
      lock_q <= 1'b0;
    end
  end

  // error flag kept until reported by a later accepted command other than the lock command
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      err_q <= 1'b0;
    end else if (param_ev) begin
      err_q <= r_err;
    end else if (accept && cmd_index_s != card_lock_pkg::CMD_LOCK) begin
      err_q <= 1'b0;
    end
  end

  // bus width
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      width4_q <= card_lock_pkg::RST_WIDTH4;
    end else if (accept && !is_app && cmd_index_s == card_lock_pkg::CMD_RESET) begin
      width4_q <= 1'b0;
    end else if (accept && is_app && cmd_index_s == card_lock_pkg::ACMD_BUS_WIDTH) begin
      width4_q <= width4_arg_s;
    end
  end

  // command response with status
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      resp_valid_out <= 1'b0;
      resp_status_out <= '0;
    end else begin
      resp_valid_out <= cmd_ev;
      if (cmd_ev) begin
        resp_status_out <= '0;
        resp_status_out[card_lock_pkg::BIT_LOCKED] <= lock_q;
        resp_status_out[card_lock_pkg::BIT_LOCK_ERR] <= err_q;
        resp_status_out[card_lock_pkg::BIT_ILLEGAL] <= !accept;
        resp_status_out[card_lock_pkg::BIT_APP_CMD] <= accept && (is_app ||
          cmd_index_s == card_lock_pkg::CMD_APP);
      end
    end
  end

  // single-cycle action pulses toward the storage side
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      erase_user_area_out <= 1'b0;
      password_clear_out <= 1'b0;
      password_write_out <= 1'b0;
      permanent_write_protect_set_out <= 1'b0;
      temporary_write_protect_clear_out <= 1'b0;
      group_write_protect_clear_out <= 1'b0;
    end else begin
      // erase engine request spares the secure area
      erase_user_area_out <= erase_start;
      password_clear_out <= (param_ev && r_clr) || erase_end;
      password_write_out <= param_ev && r_set;
      permanent_write_protect_set_out <= erase_start && !LOCK_TYPE2 &&
        permanent_write_protect_in;
      temporary_write_protect_clear_out <= erase_end && LOCK_TYPE2 &&
        temporary_write_protect_in;
      group_write_protect_clear_out <= erase_end && LOCK_TYPE2 &&
        group_write_protect_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      lock_state_flag_out <= 1'b0;
      lock_op_error_flag_out <= 1'b0;
      bus_width4_out <= 1'b0;
      erase_busy_out <= 1'b0;
    end else begin
      lock_state_flag_out <= lock_q;
      lock_op_error_flag_out <= err_q;
      bus_width4_out <= width4_q;
      erase_busy_out <= busy;
    end
  end

  logic unused_ok;
  assign unused_ok = &{1'b0, erase_error_in, erase_type1_pwp_q, lock_param_in[7:4], pins_s[1:0]};
endmodule // card_lock_unlock_control

// File: dv/card_lock_props.sv
module card_lock_props #(
  parameter bit LOCK_TYPE2 = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic erase_done_in,
  input wire logic permanent_write_protect_in,
  input wire logic resp_valid_out,
  input wire logic [card_lock_pkg::STATUS_W-1:0] resp_status_out,
  input wire logic lock_state_flag_out,
  input wire logic bus_width4_out,
  input wire logic erase_user_area_out,
  input wire logic erase_busy_out,
  input wire logic password_clear_out,
  input wire logic temporary_write_protect_clear_out,
  input wire logic group_write_protect_clear_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_resp_one_cycle: assert property (resp_valid_out |=> !resp_valid_out)
    else $error("response pulse longer than one cycle");
  a_lock_in_status: assert property (resp_valid_out |-> resp_status_out[25] == lock_state_flag_out)
    else $error("status lock bit differs from lock state");
  a_width_only_unlocked: assert property ($rose(bus_width4_out) |-> !lock_state_flag_out)
    else $error("bus width changed while locked");
  a_unlocked_no_illegal: assert property (resp_valid_out && !lock_state_flag_out |-> !resp_status_out[22])
    else $error("unlocked card flagged illegal command");
  a_erase_keeps_lock: assert property (erase_user_area_out |-> lock_state_flag_out ##1 lock_state_flag_out[*3])
    else $error("lock dropped at erase start");
  a_erase_not_pwp: assert property (erase_user_area_out |-> !LOCK_TYPE2 || !permanent_write_protect_in)
    else $error("erase started under permanent protection");
  a_twp_clear_end: assert property (temporary_write_protect_clear_out |->
    LOCK_TYPE2 && password_clear_out && $past(erase_done_in))
    else $error("temporary protection cleared outside erase end");
  a_gwp_clear_end: assert property (group_write_protect_clear_out |->
    LOCK_TYPE2 && password_clear_out && $past(erase_done_in))
    else $error("group protection cleared outside erase end");
  a_busy_ends: assert property (erase_done_in && erase_busy_out |-> ##[1:3] !erase_busy_out)
    else $error("erase busy did not end");
  c_erase: cover property (erase_user_area_out);
  c_wp_clear: cover property (temporary_write_protect_clear_out);
  c_illegal: cover property (resp_valid_out && resp_status_out[22]);
endmodule // card_lock_props

// File: dv/sd_host_model.sv
module sd_host_model (
  input wire logic clk_in,
  output logic sd_clk_out,
  output logic cmd_strobe_out,
  output logic [5:0] cmd_index_out,
  output logic bus_width4_arg_out,
  output logic param_strobe_out,
  output logic [7:0] lock_param_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sd_clk_out = 1'b0;
    cmd_strobe_out = 1'b0;
    param_strobe_out = 1'b0;
    cmd_index_out = 6'h00;
    bus_width4_arg_out = 1'b0;
    lock_param_out = 8'h00;
  end
  // one frame in 1-bit width, bus clock only runs inside it
  task automatic frame(input logic is_cmd, input logic [5:0] idx, input logic [7:0] val);
    @(posedge clk_in) #2;
    cmd_strobe_out = is_cmd;
    param_strobe_out = !is_cmd;
    cmd_index_out = idx;
    bus_width4_arg_out = val[0];
    lock_param_out = val;
    repeat (4) @(posedge clk_in);
    #2 sd_clk_out = 1'b1;
    repeat (4) @(posedge clk_in);
    #2 sd_clk_out = 1'b0;
    cmd_strobe_out = 1'b0;
    param_strobe_out = 1'b0;
    cmd_index_out = ~idx;
    bus_width4_arg_out = ~val[0];
    lock_param_out = ~val;
    repeat (6) @(posedge clk_in);
  endtask
endmodule // sd_host_model

// File: dv/tb_card_lock_unlock_control.sv
module tb_card_lock_unlock_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0, rst_in = 1'b1, sd_clk, cmd_stb, w4_arg, par_stb, pw_exists = 1'b1, pw_match = 1'b1;
  logic permanent_write_protect = 1'b0, temporary_write_protect = 1'b1, group_write_protect = 1'b1, done = 1'b0, e_err = 1'b0;
  logic [5:0] idx;
  logic [7:0] par;
  logic resp_valid_out, lock_state_flag_out, lock_op_error_flag_out, bus_width4_out, erase_busy_out;
  logic erase_user_area_out, password_clear_out, password_write_out, pwp_set, twp_clr, gwp_clr;
  logic [31:0] resp_status_out, rnd = 32'hbcdf4245;
  logic [2:0] exp_q[$];
  int errors = 0, cmp_count = 0, n_er = 0, n_pc = 0, n_pw = 0, n_tc = 0, n_gc = 0, n_ps = 0;
  logic [5:0] acc[11] = '{6'h00, 6'h02, 6'h03, 6'h04, 6'h07, 6'h09, 6'h0a, 6'h0c, 6'h0d, 6'h0f, 6'h10};
  logic [5:0] ill[4] = '{6'h11, 6'h18, 6'h20, 6'h26};
  logic [3:0] bad[6] = '{4'h3, 4'h7, 4'h6, 4'h9, 4'hc, 4'h4};
  always #12.5 clk_in = ~clk_in;
  sd_host_model u_sd_host_model (.clk_in(clk_in), .sd_clk_out(sd_clk), .cmd_strobe_out(cmd_stb),
    .cmd_index_out(idx), .bus_width4_arg_out(w4_arg), .param_strobe_out(par_stb), .lock_param_out(par));
  card_lock_unlock_control u_card_lock_unlock_control (.clk_in(clk_in), .rst_in(rst_in), .sd_clk_in(sd_clk),
    .cmd_strobe_in(cmd_stb), .cmd_index_in(idx), .bus_width4_arg_in(w4_arg), .param_strobe_in(par_stb),
    .lock_param_in(par), .password_exists_in(pw_exists), .password_match_in(pw_match),
    .permanent_write_protect_in(permanent_write_protect), .temporary_write_protect_in(temporary_write_protect), .group_write_protect_in(group_write_protect),
    .erase_done_in(done), .erase_error_in(e_err), .resp_valid_out(resp_valid_out),
    .resp_status_out(resp_status_out), .lock_state_flag_out(lock_state_flag_out),
    .lock_op_error_flag_out(lock_op_error_flag_out), .bus_width4_out(bus_width4_out),
    .erase_user_area_out(erase_user_area_out), .erase_busy_out(erase_busy_out),
    .password_clear_out(password_clear_out), .password_write_out(password_write_out),
    .permanent_write_protect_set_out(pwp_set), .temporary_write_protect_clear_out(twp_clr),
    .group_write_protect_clear_out(gwp_clr));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // expected {locked, lock error, illegal} noted per command
  task automatic cmd(input logic [5:0] i, input logic a, input logic [2:0] e);
    exp_q.push_back(e);
    u_sd_host_model.frame(1'b1, i, {7'h00, a});
  endtask
  task automatic acmd(input logic [5:0] i, input logic a, input logic [2:0] e);
    cmd(card_lock_pkg::CMD_APP, 1'b0, {e[2], 2'b00});
    cmd(i, a, e);
  endtask
  task automatic lockdata(input logic [3:0] p);
    rnd = xs(rnd);
    u_sd_host_model.frame(1'b0, 6'h00, {rnd[7:4], p});
    repeat (3) @(posedge clk_in);
  endtask
  always @(posedge clk_in) begin
    n_er <= n_er + erase_user_area_out;
    n_pc <= n_pc + password_clear_out;
    n_pw <= n_pw + password_write_out;
    n_tc <= n_tc + twp_clr;
    n_gc <= n_gc + gwp_clr;
    n_ps <= n_ps + pwp_set;
    if (resp_valid_out === 1'b1) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0);
      else check({resp_status_out[25], resp_status_out[24], resp_status_out[22]}, exp_q.pop_front());
    end
  end
  initial begin
    #200000;
    errors++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge clk_in);
    #2 rst_in = 1'b0;
    repeat (5) @(posedge clk_in);
    check(lock_state_flag_out, 1);
    foreach (acc[i]) cmd(acc[i], 1'b0, 3'b100);
    acmd(card_lock_pkg::ACMD_OP_COND, 1'b0, 3'b100);
    foreach (ill[i]) cmd(ill[i], 1'b0, 3'b101);
    acmd(card_lock_pkg::ACMD_BUS_WIDTH, 1'b1, 3'b101);
    check(bus_width4_out, 0);
    foreach (bad[i]) begin
      cmd(card_lock_pkg::CMD_LOCK, 1'b0, 3'b100);
      lockdata(bad[i]);
      check(lock_op_error_flag_out, 1);
      cmd(card_lock_pkg::CMD_STATUS, 1'b0, 3'b110);
    end
    permanent_write_protect = 1'b1;
    cmd(card_lock_pkg::CMD_LOCK, 1'b0, 3'b100);
    lockdata(card_lock_pkg::CODE_ERASE);
    check({lock_state_flag_out, lock_op_error_flag_out}, 2'b11);
    check(n_er, 0);
    cmd(card_lock_pkg::CMD_STATUS, 1'b0, 3'b110);
    permanent_write_protect = 1'b0;
    cmd(card_lock_pkg::CMD_LOCK, 1'b0, 3'b100);
    lockdata(card_lock_pkg::CODE_ERASE);
    check(n_er, 1);
    check(erase_busy_out, 1);
    e_err = 1'b1;
    repeat (20) @(posedge clk_in);
    check(lock_state_flag_out, 1);
    check(n_tc, 0);
    check(n_gc, 0);
    #2 done = 1'b1;
    e_err = 1'b0;
    @(posedge clk_in) #2 done = 1'b0;
    repeat (4) @(posedge clk_in);
    check({lock_state_flag_out, lock_op_error_flag_out, erase_busy_out}, 3'b000);
    check(n_tc, 1);
    check(n_gc, 1);
    check(n_pc, 1);
    check(n_ps, 0);
    pw_exists = 1'b0;
    temporary_write_protect = 1'b0;
    group_write_protect = 1'b0;
    cmd(card_lock_pkg::CMD_STATUS, 1'b0, 3'b000);
    cmd(6'h11, 1'b0, 3'b000);
    acmd(card_lock_pkg::ACMD_BUS_WIDTH, 1'b1, 3'b000);
    check(bus_width4_out, 1);
    cmd(card_lock_pkg::CMD_LOCK, 1'b0, 3'b000);
    lockdata(card_lock_pkg::CODE_CLR);
    check(lock_op_error_flag_out, 1);
    cmd(card_lock_pkg::CMD_STATUS, 1'b0, 3'b010);
    cmd(card_lock_pkg::CMD_LOCK, 1'b0, 3'b000);
    lockdata(card_lock_pkg::CODE_SET_LOCK);
    check(lock_state_flag_out, 1);
    check(n_pw, 1);
    pw_exists = 1'b1;
    acmd(card_lock_pkg::ACMD_BUS_WIDTH, 1'b0, 3'b101);
    check(bus_width4_out, 1);
    cmd(card_lock_pkg::CMD_RESET, 1'b0, 3'b100);
    check(bus_width4_out, 0);
    check(exp_q.size(), 0);
    complete_run();
  end
endmodule // tb_card_lock_unlock_control
bind card_lock_unlock_control card_lock_props #(.LOCK_TYPE2(LOCK_TYPE2)) u_card_lock_props (.clk_in(clk_in),
  .rst_in(rst_in), .erase_done_in(erase_done_in), .permanent_write_protect_in(permanent_write_protect_in),
  .resp_valid_out(resp_valid_out), .resp_status_out(resp_status_out), .lock_state_flag_out(lock_state_flag_out),
  .bus_width4_out(bus_width4_out), .erase_user_area_out(erase_user_area_out), .erase_busy_out(erase_busy_out),
  .password_clear_out(password_clear_out), .temporary_write_protect_clear_out(temporary_write_protect_clear_out),
  .group_write_protect_clear_out(group_write_protect_clear_out));
